// ==== rtl/flash_regs_pkg.sv ====
// Constants and carriers for the flash security and configuration registers.
// Assumes an 8-bit register port with reads answered one cycle later.
package flash_regs_pkg;

  // ==========================================================
  // Register port
  localparam int         ADDR_W = 4;
  localparam int         DATA_W = 8;
  localparam logic [3:0] OFS_FLASH_SECURITY    = 4'h1;
  localparam logic [3:0] OFS_CMD_OBJECT_INDEX  = 4'h2;
  localparam logic [3:0] OFS_FLASH_RSV_ZERO    = 4'h3;
  localparam logic [3:0] OFS_FLASH_CONFIG      = 4'h4;
  localparam logic [3:0] OFS_ECC_ERROR_CONFIG  = 4'h5;
  localparam logic [3:0] OFS_FLASH_STATUS      = 4'h6;
  localparam logic [3:0] OFS_ECC_ERROR_STATUS  = 4'h7;
  localparam logic [3:0] OFS_EVENT_STATUS      = 4'h8;
  localparam logic [3:0] OFS_EVENT_MASK        = 4'h9;

  // ==========================================================
  // Field positions
  localparam int BIT_DONE_IRQ_EN   = 7;
  localparam int BIT_SKIP_SINGLE   = 4;
  localparam int BIT_FORCE_DOUBLE  = 1;
  localparam int BIT_FORCE_SINGLE  = 0;
  localparam int BIT_CMD_COMPLETE  = 7;
  localparam int BIT_DOUBLE_FAULT  = 1;
  localparam int BIT_SINGLE_FAULT  = 0;
  localparam int BIT_EV_DONE       = 2;
  localparam int BIT_EV_DOUBLE     = 1;
  localparam int BIT_EV_SINGLE     = 0;

  // ==========================================================
  // Field values and reset values
  localparam logic [1:0] KEY_ACCESS_ON    = 2'h2;
  localparam logic [1:0] LOCK_UNSECURED   = 2'h2;
  localparam logic [7:0] SECURITY_ALL_SET = 8'hFF;
  localparam logic [7:0] RST_SECURITY     = 8'hFF;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic       RST_CMD_COMPLETE = 1'b0;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] sec_byte;
    logic       double_fault;
  } nv_load_s;

  typedef struct packed {
    logic read;
    logic single_fault;
    logic double_fault;
  } array_read_s;

  typedef struct packed {
    logic [1:0] backdoor_access_field;
    logic [3:0] reserved_nonvolatile_bits;
    logic [1:0] lock_state_field;
  } security_s;

endpackage

// ==== rtl/flash_security_config_regs.sv ====
// Security, command-index, reserved and configuration registers of a flash
// controller, with command-complete and ECC fault flags and interrupts.
// Assumes the sequencer and array read path are outside and signal by pulses.
`timescale 1ns/1ps

module flash_security_config_regs
  import flash_regs_pkg::*;
#(
  parameter int INDEX_W = 3
) (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // Register port
  input  wire flash_regs_pkg::reg_req_s    reg_req,
  output logic [flash_regs_pkg::DATA_W-1:0] reg_rdata,
  // Reset-sequence load of the security byte
  input  wire flash_regs_pkg::nv_load_s    nv_load,
  // Backdoor key comparison succeeded
  input  wire logic                        backdoor_unlock,
  // Command sequencer
  input  wire logic                        cmd_done,
  output logic                             cmd_launch,
  output logic [INDEX_W-1:0]               object_word_select,
  // Array read path
  input  wire flash_regs_pkg::array_read_s array_rd,
  output logic                             ecc_capture_stb,
  // Security state
  output logic                             key_access_enabled,
  output logic                             secured,
  // Interrupts
  output logic                             done_irq,
  output logic                             fault_irq,
  output logic                             irq
);
  import flash_regs_pkg::*;

  // ==========================================================
  // Decode
  function automatic logic hit(input reg_req_s r, input logic [3:0] ofs, input logic is_wr);
    hit = (is_wr ? r.wr : r.rd) && (r.addr == ofs);
  endfunction

  logic [7:0]         flash_security_reg;
  logic [INDEX_W-1:0] index_reg;
  logic               done_irq_en_reg;
  logic               skip_single_reg;
  logic               force_double_reg;
  logic               force_single_reg;
  logic [1:0]         ecc_error_config_reg;
  logic               cmd_complete_reg;
  logic               double_fault_reg;
  logic               single_fault_reg;
  logic [2:0]         event_status_reg;
  logic [2:0]         event_mask_reg;
  logic [7:0]         rdata_next;
  security_s          sec;

  assign sec = flash_security_reg;

  logic wr_cfg;
  logic wr_stat;
  logic wr_ecst;
  logic rd_evst;
  logic launch;
  logic set_double;
  logic set_single;
  logic set_done;
  logic clr_double;
  logic clr_single;
  logic wr_index;
  logic wr_ecfg;
  logic wr_mask;

  assign wr_cfg  = hit(reg_req, OFS_FLASH_CONFIG, 1'b1);
  assign wr_stat = hit(reg_req, OFS_FLASH_STATUS, 1'b1);
  assign wr_ecst = hit(reg_req, OFS_ECC_ERROR_STATUS, 1'b1);
  assign rd_evst = hit(reg_req, OFS_EVENT_STATUS, 1'b0);
  assign wr_index = hit(reg_req, OFS_CMD_OBJECT_INDEX, 1'b1);
  assign wr_ecfg  = hit(reg_req, OFS_ECC_ERROR_CONFIG, 1'b1);
  assign wr_mask  = hit(reg_req, OFS_EVENT_MASK, 1'b1);
  // write of one launches
  // A write of one while a command runs is ignored
  assign launch  = wr_stat && reg_req.wdata[BIT_CMD_COMPLETE] && cmd_complete_reg;
  // Done while already complete is not a new event
  assign set_done = cmd_done && !cmd_complete_reg;
  assign set_double = array_rd.read && (array_rd.double_fault || force_double_reg);
  assign set_single = array_rd.read &&
                      ((array_rd.single_fault && !skip_single_reg) || force_single_reg);
  // Write one to clear, ECC status only
  assign clr_double = wr_ecst && reg_req.wdata[BIT_DOUBLE_FAULT];
  assign clr_single = wr_ecst && reg_req.wdata[BIT_SINGLE_FAULT];

  // ==========================================================
  // Security register
  // Reload wins over unlock; a load restarts from the stored byte, or from all ones on a double fault
  logic [7:0] flash_security_next;

  always_comb begin
    flash_security_next = flash_security_reg;
    if (nv_load.valid) begin
      flash_security_next = nv_load.double_fault ? SECURITY_ALL_SET : nv_load.sec_byte;
    end else if (backdoor_unlock && sec.backdoor_access_field == KEY_ACCESS_ON) begin
      flash_security_next[1:0] = LOCK_UNSECURED;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flash_security_reg <= RST_SECURITY;
    end else begin
      flash_security_reg <= flash_security_next;
    end
  end

  // ==========================================================
  // Index and configuration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_reg <= '0;
    end else if (wr_index) begin
      index_reg <= reg_req.wdata[INDEX_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_irq_en_reg  <= 1'b0;
      skip_single_reg  <= 1'b0;
      force_double_reg <= 1'b0;
      force_single_reg <= 1'b0;
    end else if (wr_cfg) begin
      // force single clears by write
      // Force bits stay set until software writes zero
      done_irq_en_reg  <= reg_req.wdata[BIT_DONE_IRQ_EN];
      skip_single_reg  <= reg_req.wdata[BIT_SKIP_SINGLE];
      force_double_reg <= reg_req.wdata[BIT_FORCE_DOUBLE];
      force_single_reg <= reg_req.wdata[BIT_FORCE_SINGLE];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ecc_error_config_reg <= '0;
    end else if (wr_ecfg) begin
      ecc_error_config_reg <= reg_req.wdata[1:0];
    end
  end

  // ==========================================================
  // Command complete flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_complete_reg <= RST_CMD_COMPLETE;
    end else begin
      if (set_done) begin
        cmd_complete_reg <= 1'b1;
      end else if (launch) begin
        cmd_complete_reg <= 1'b0;
      end
    end
  end

  // Launch strobe lasts exactly one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_launch <= 1'b0;
    end else begin
      cmd_launch <= launch;
    end
  end

  // ==========================================================
  // ECC fault flags, write one to clear; a set in the same cycle wins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      double_fault_reg <= 1'b0;
    end else if (set_double) begin
      double_fault_reg <= 1'b1;
    end else if (clr_double) begin
      double_fault_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      single_fault_reg <= 1'b0;
    end else if (set_single) begin
      single_fault_reg <= 1'b1;
    end else if (clr_single) begin
      single_fault_reg <= 1'b0;
    end
  end

  // Capture only genuine faults, forced ones leave the capture alone
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ecc_capture_stb <= 1'b0;
    end else begin
      ecc_capture_stb <= array_rd.read &&
                         (array_rd.double_fault ||
                          (array_rd.single_fault && !skip_single_reg));
    end
  end

  // ==========================================================
  // Event status, cleared by reading it; an event in the read cycle survives
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_status_reg <= '0;
    end else begin
      event_status_reg <= (rd_evst ? 3'h0 : event_status_reg) |
                          {set_done, set_double, set_single};
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_mask_reg <= '0;
    end else if (wr_mask) begin
      event_mask_reg <= reg_req.wdata[2:0];
    end
  end

  // ==========================================================
  // Interrupt outputs registered from next-state terms, state outputs from stored bits
  logic cc_next;
  logic df_next;
  logic sf_next;
  logic [2:0] ev_next;

  always_comb begin
    cc_next = set_done ? 1'b1 : (launch ? 1'b0 : cmd_complete_reg);
    df_next = set_double | (double_fault_reg & ~clr_double);
    sf_next = set_single | (single_fault_reg & ~clr_single);
    ev_next = (rd_evst ? 3'h0 : event_status_reg) | {set_done, set_double, set_single};
  end

  // level while both are one
  // Uses the written enable so the request tracks the register exactly
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_irq <= 1'b0;
    end else begin
      done_irq <= (wr_cfg ? reg_req.wdata[BIT_DONE_IRQ_EN] : done_irq_en_reg) & cc_next;
    end
  end

  // skipped singles never set the flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fault_irq <= 1'b0;
    end else begin
      fault_irq <= (ecc_error_config_reg[1] & df_next) | (ecc_error_config_reg[0] & sf_next);
    end
  end

  // Masked event summary, one level for the CPU
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_next & event_mask_reg);
    end
  end

  // Decoded from stored bits; a reload shows two cycles later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      key_access_enabled <= 1'b0;
    end else begin
      key_access_enabled <= sec.backdoor_access_field == KEY_ACCESS_ON;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      secured <= 1'b1;
    end else begin
      secured <= sec.lock_state_field != LOCK_UNSECURED;
    end
  end

  // Copy lags the index register by one cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      object_word_select <= '0;
    end else begin
      object_word_select <= index_reg;
    end
  end

  // ==========================================================
  // Read data, one cycle after the strobe
  // Map, offset and contents:
  //   1  security, read only
  //   2  index, low bits only
  //   3  reserved, always zero
  //   4  config: done enable, skip single, force double, force single
  //   5  ECC interrupt enables, double and single
  //   6  status, complete flag in the top bit
  //   7  ECC status, write one to clear
  //   8  event status, read to clear
  //   9  event mask, same layout as event status
  // Cycles without a read return zero so stale data never lingers
  always_comb begin
    rdata_next = RST_ZERO;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        OFS_FLASH_SECURITY:   rdata_next = flash_security_reg;
        OFS_CMD_OBJECT_INDEX: rdata_next = {{(DATA_W-INDEX_W){1'b0}}, index_reg};
        // reserved reads zero
        // No storage behind it at all
        OFS_FLASH_RSV_ZERO:   rdata_next = RST_ZERO;
        OFS_FLASH_CONFIG:     rdata_next = {done_irq_en_reg, 2'b00, skip_single_reg,
                                            2'b00, force_double_reg, force_single_reg};
        OFS_ECC_ERROR_CONFIG: rdata_next = {6'h00, ecc_error_config_reg};
        OFS_FLASH_STATUS:     rdata_next = {cmd_complete_reg, 7'h00};
        OFS_ECC_ERROR_STATUS: rdata_next = {6'h00, double_fault_reg, single_fault_reg};
        OFS_EVENT_STATUS:     rdata_next = {5'h00, event_status_reg};
        OFS_EVENT_MASK:       rdata_next = {5'h00, event_mask_reg};
        default:              rdata_next = RST_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

endmodule

// ==== sim/cpu_bus_model.sv ====
// CPU-side master of the register port.
// Assumes each call starts just after a rising edge.
`timescale 1ns/1ps
module cpu_bus_model
  import flash_regs_pkg::*;
(
  // Register port
  input  wire logic                       clock,
  output flash_regs_pkg::reg_req_s        reg_req,
  input  wire logic [flash_regs_pkg::DATA_W-1:0] reg_rdata
);
  initial reg_req = '0;
  // ==========
  // One strobe cycle, answer taken at the next edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    reg_req <= '0;
    @(posedge clock);
    q = reg_rdata;
  endtask
endmodule

// ==== sim/flash_regs_checker_assertions.sv ====
// Port checker for the flash security and configuration registers.
// Assumes binding to the block, one clock, synchronous active-low reset.
`timescale 1ns/1ps
module flash_regs_checker
  import flash_regs_pkg::*;
#(
  parameter int INDEX_W = 3
) (
  // Clock and reset
  input wire logic                         clock,
  input wire logic                         rst_n,
  // Watched ports
  input wire flash_regs_pkg::reg_req_s     reg_req,
  input wire logic [7:0]                   reg_rdata,
  input wire flash_regs_pkg::nv_load_s     nv_load,
  input wire logic                         backdoor_unlock,
  input wire logic                         cmd_done,
  input wire logic                         cmd_launch,
  input wire logic [INDEX_W-1:0]           object_word_select,
  input wire flash_regs_pkg::array_read_s  array_rd,
  input wire logic                         ecc_capture_stb,
  input wire logic                         key_access_enabled,
  input wire logic                         secured,
  input wire logic                         done_irq,
  input wire logic                         fault_irq,
  input wire logic                         irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [7:0] sb;
  // ==========
  // Last loaded byte
  always_ff @(posedge clock) begin
    if (nv_load.valid) begin
      sb <= nv_load.sec_byte;
    end
  end
  AST_SEC_LOAD: assert property (nv_load.valid && !nv_load.double_fault |-> ##[1:2]
    (key_access_enabled == (sb[7:6] == KEY_ACCESS_ON)) && (secured == (sb[1:0] != LOCK_UNSECURED)))
    else $error("security decode wrong after load");
  AST_SEC_DFAULT: assert property (nv_load.valid && nv_load.double_fault |-> ##[1:2]
    secured && !key_access_enabled) else $error("faulty load not secured");
  AST_SEC_RO: assert property (reg_req.wr && reg_req.addr == OFS_FLASH_SECURITY &&
    !nv_load.valid && !backdoor_unlock && !$past(nv_load.valid) && !$past(backdoor_unlock)
    |=> $stable(secured) && $stable(key_access_enabled)) else $error("security write took");
  AST_UNLOCK: assert property (backdoor_unlock && key_access_enabled && !nv_load.valid
    |-> ##[1:2] !secured) else $error("unlock left secured");
  AST_INDEX: assert property (reg_req.wr && reg_req.addr == OFS_CMD_OBJECT_INDEX
    |-> ##2 object_word_select == INDEX_W'($past(reg_req.wdata, 2))) else $error("index out");
  AST_RSV_ZERO: assert property (reg_req.rd && reg_req.addr == OFS_FLASH_RSV_ZERO
    |=> reg_rdata == 8'h00) else $error("reserved read not zero");
  AST_CFG_ZERO: assert property (reg_req.rd && reg_req.addr == OFS_FLASH_CONFIG
    |=> (reg_rdata & 8'h6C) == 8'h00) else $error("config spare bits set");
  AST_LAUNCH: assert property (cmd_launch |-> $past(reg_req.wr) && $past(reg_req.wdata[7])
    && $past(reg_req.addr) == OFS_FLASH_STATUS) else $error("launch without write");
  AST_DONE_CAUSE: assert property ($rose(done_irq) |-> $past(cmd_done) ||
    ($past(reg_req.wr) && $past(reg_req.addr) == OFS_FLASH_CONFIG)) else $error("stray done irq");
  AST_DONE_HOLD: assert property (done_irq && !reg_req.wr |=> done_irq)
    else $error("done irq dropped");
  AST_CAPTURE: assert property (ecc_capture_stb |-> $past(array_rd.read) &&
    ($past(array_rd.double_fault) || $past(array_rd.single_fault))) else $error("forced capture");
  AST_CAPTURE_DBL: assert property (array_rd.read && array_rd.double_fault |=> ecc_capture_stb)
    else $error("double fault not captured");
  cover property (cmd_launch);
  cover property (fault_irq && irq);
  cover property (backdoor_unlock && key_access_enabled);
endmodule

bind flash_security_config_regs flash_regs_checker #(.INDEX_W(INDEX_W)) u_chk (
  .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .nv_load(nv_load), .backdoor_unlock(backdoor_unlock), .cmd_done(cmd_done),
  .cmd_launch(cmd_launch), .object_word_select(object_word_select), .array_rd(array_rd),
  .ecc_capture_stb(ecc_capture_stb), .key_access_enabled(key_access_enabled),
  .secured(secured), .done_irq(done_irq), .fault_irq(fault_irq), .irq(irq));

// ==== sim/flash_security_config_regs_tb.sv ====
// Self-checking bench for the flash security and configuration registers.
// Assumes the CPU bus model and the bound port checker.
`timescale 1ns/1ps
module flash_security_config_regs_tb;
  import flash_regs_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        backdoor_unlock = 1'b0;
  logic        cmd_done = 1'b0;
  nv_load_s    nv_load = '0;
  array_read_s array_rd = '0;
  reg_req_s    reg_req;
  logic [7:0]  reg_rdata;
  logic [7:0]  q;
  logic [2:0]  object_word_select;
  logic        cmd_launch, ecc_capture_stb, key_access_enabled, secured;
  logic        done_irq, fault_irq, irq;
  int          num_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  initial forever #2 clock = ~clock;
  cpu_bus_model u_cpu (.clock(clock), .reg_req(reg_req), .reg_rdata(reg_rdata));
  flash_security_config_regs u_dut (
    .clock(clock), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .nv_load(nv_load), .backdoor_unlock(backdoor_unlock), .cmd_done(cmd_done),
    .cmd_launch(cmd_launch), .object_word_select(object_word_select), .array_rd(array_rd),
    .ecc_capture_stb(ecc_capture_stb), .key_access_enabled(key_access_enabled),
    .secured(secured), .done_irq(done_irq), .fault_irq(fault_irq), .irq(irq));

  // ==========
  // Helpers
  task automatic end_sim();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    u_cpu.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // Two idle edges after each pulse let registered outputs land
  task automatic pulse(input logic u, input logic d);
    backdoor_unlock <= u;
    cmd_done <= d;
    @(posedge clock);
    backdoor_unlock <= 1'b0;
    cmd_done <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  task automatic nv(input logic [7:0] b, input logic f);
    nv_load <= '{valid: 1'b1, sec_byte: b, double_fault: f};
    @(posedge clock);
    nv_load <= '0;
    repeat (2) @(posedge clock);
  endtask
  task automatic arr(input logic s, input logic d, input logic cap);
    array_rd <= '{read: 1'b1, single_fault: s, double_fault: d};
    @(posedge clock);
    array_rd <= '0;
    @(posedge clock);
    chk({7'h00, ecc_capture_stb}, {7'h00, cap});
    @(posedge clock);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    rd(OFS_FLASH_SECURITY, RST_SECURITY);
    chk({7'h00, secured}, 8'h01);
    rd(OFS_FLASH_CONFIG, RST_ZERO);
    rd(OFS_FLASH_RSV_ZERO, RST_ZERO);
    rd(4'hF, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_sec();
    for (int i = 0; i < 4; i++) begin
      nv({i[1:0], 4'hF, i[1:0]}, 1'b0);
      rd(OFS_FLASH_SECURITY, {i[1:0], 4'hF, i[1:0]});
      chk({7'h00, key_access_enabled}, {7'h00, i == 2});
      chk({7'h00, secured}, {7'h00, i != 2});
    end
    wr(OFS_FLASH_SECURITY, 8'h00);
    rd(OFS_FLASH_SECURITY, 8'hFF);
    nv(8'h81, 1'b0);
    pulse(1'b1, 1'b0);
    rd(OFS_FLASH_SECURITY, 8'h82);
    nv(8'h81, 1'b1);
    rd(OFS_FLASH_SECURITY, 8'hFF);
    pulse(1'b1, 1'b0);
    chk({7'h00, secured}, 8'h01);
    $display("test security done");
  endtask
  task automatic t_cfg();
    wr(OFS_FLASH_CONFIG, 8'hFF);
    rd(OFS_FLASH_CONFIG, 8'h93);
    wr(OFS_FLASH_CONFIG, 8'h00);
    rd(OFS_FLASH_CONFIG, 8'h00);
    wr(OFS_CMD_OBJECT_INDEX, 8'hFD);
    rd(OFS_CMD_OBJECT_INDEX, 8'h05);
    chk({5'h00, object_word_select}, 8'h05);
    wr(OFS_FLASH_RSV_ZERO, 8'hFF);
    rd(OFS_FLASH_RSV_ZERO, 8'h00);
    $display("test config done");
  endtask
  task automatic t_done();
    wr(OFS_EVENT_MASK, 8'h07);
    wr(OFS_ECC_ERROR_CONFIG, 8'h03);
    wr(OFS_FLASH_CONFIG, 8'h80);
    pulse(1'b0, 1'b1);
    chk({7'h00, done_irq}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(OFS_FLASH_STATUS, 8'h80);
    wr(OFS_FLASH_STATUS, 8'h80);
    chk({7'h00, cmd_launch}, 8'h01);
    rd(OFS_FLASH_STATUS, 8'h00);
    chk({7'h00, done_irq}, 8'h00);
    rd(OFS_EVENT_STATUS, 8'h04);
    rd(OFS_EVENT_STATUS, 8'h00);
    wr(OFS_FLASH_CONFIG, 8'h00);
    pulse(1'b0, 1'b1);
    chk({7'h00, done_irq}, 8'h00);
    rd(OFS_EVENT_STATUS, 8'h04);
    $display("test done irq done");
  endtask
  task automatic t_fault();
    arr(1'b0, 1'b1, 1'b1);
    rd(OFS_ECC_ERROR_STATUS, 8'h02);
    chk({6'h00, fault_irq, irq}, 8'h03);
    wr(OFS_ECC_ERROR_STATUS, 8'h02);
    wr(OFS_FLASH_CONFIG, 8'h02);
    arr(1'b0, 1'b0, 1'b0);
    rd(OFS_ECC_ERROR_STATUS, 8'h02);
    rd(OFS_FLASH_CONFIG, 8'h02);
    wr(OFS_ECC_ERROR_STATUS, 8'h02);
    wr(OFS_FLASH_CONFIG, 8'h01);
    arr(1'b0, 1'b0, 1'b0);
    rd(OFS_ECC_ERROR_STATUS, 8'h01);
    rd(OFS_FLASH_CONFIG, 8'h01);
    wr(OFS_ECC_ERROR_STATUS, 8'h01);
    wr(OFS_FLASH_CONFIG, 8'h10);
    arr(1'b1, 1'b0, 1'b0);
    rd(OFS_ECC_ERROR_STATUS, 8'h00);
    wr(OFS_FLASH_CONFIG, 8'h00);
    wr(OFS_EVENT_MASK, 8'h00);
    arr(1'b1, 1'b0, 1'b1);
    rd(OFS_ECC_ERROR_STATUS, 8'h01);
    chk({6'h00, fault_irq, irq}, 8'h02);
    rd(OFS_EVENT_STATUS, 8'h03);
    $display("test faults done");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_sec();
    t_cfg();
    t_done();
    t_fault();
    end_sim();
  end
endmodule
